// *** hw/swcfg_top.sv ***
// Slave-side status/config and nonvolatile control registers with the
// bus reset, presence and sleep logic. Assumes a bit engine outside has
// decoded commands, register writes and reads; inputs are synchronous.
`timescale 1ns/1ps
module swcfg_top #(
    parameter int RESET_CYC = swcfg_pkg::RESET_LOW_CYC,
    parameter int SLEEP_CYC = swcfg_pkg::SLEEP_LOW_CYC,
    parameter int EEC_CYC   = swcfg_pkg::EEC_CYC,
    parameter int PRES_CYC  = swcfg_pkg::PRES_LEN_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_dq,
    output logic             o_dq_out,
    output logic             o_dq_oe_n,
    output logic             o_bus_reset,
    input  wire logic        i_net_cmd_valid,
    input  wire logic [7:0]  i_net_cmd,
    output logic             o_rna_hit,
    output logic [7:0]       o_rna_opcode,
    output logic [63:0]      o_net_addr,
    input  wire logic        i_fn_valid,
    input  wire logic [7:0]  i_fn_code,
    input  wire logic [7:0]  i_fn_arg,
    input  wire logic        i_wr_valid,
    input  wire logic [7:0]  i_wr_addr,
    input  wire logic [7:0]  i_wr_data,
    input  wire logic [7:0]  i_rd_addr,
    output logic [7:0]       o_rd_data,
    output logic             o_nv_wr_en,
    output logic [7:0]       o_nv_wr_addr,
    output logic [7:0]       o_nv_wr_data,
    output logic             o_nv_copy_go,
    output logic [1:0]       o_nv_copy_blk,
    output logic             o_nv_copy_busy,
    output logic [2:0]       o_blk_locked,
    input  wire logic [7:0]  i_nv_status_init,
    input  wire logic [1:0]  i_charge_state,
    input  wire logic        i_charge_supply_input,
    output logic             o_charge_start,
    output logic             o_charge_stop,
    output logic             o_chem_nimh,
    output logic             o_sleep
);
    typedef struct packed {
        logic                    init;
        logic [1:0]              chg;
        logic [7:0]              cfg;
        logic                    lock_en;
        logic [2:0]              blk_lock;
        logic                    busy;
        logic [31:0]             busy_cnt;
        logic                    sleep;
        logic                    charge_supply_input;
        logic                    chg_start;
        logic                    chg_stop;
        swcfg_pkg::swcfg_pres_e  pr_st;
        logic [31:0]             pr_cnt;
        logic                    oe_n;
        logic                    bus_rst;
        logic                    rna_hit;
        logic [7:0]              rna_op;
        logic                    nv_we;
        logic [7:0]              nv_wa;
        logic [7:0]              nv_wd;
        logic [7:0]              rd_data;
        logic                    copy_go;
        logic [1:0]              copy_blk;
        logic [63:0]             addr;
    } swcfg_top_s;

    swcfg_top_s s_q;
    swcfg_top_s s_d;
    swcfg_if    link ();

    logic [1:0] fn_blk;
    logic [1:0] wr_blk;
    logic       wr_stat;
    logic       wr_ctrl;

    swcfg_lowmon #(
        .RESET_CYC (RESET_CYC),
        .SLEEP_CYC (SLEEP_CYC)
    ) u_lowmon (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .lk    (link.mon)
    );

    swcfg_crc u_crc (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .lk    (link.gen)
    );

    // Line seen low includes our own presence drive; it is short enough
    assign link.line_low = ~i_dq;
    assign link.id56     = {swcfg_pkg::SERIAL_NUM, swcfg_pkg::FAMILY_CODE};

    // Shared address decodes
    assign fn_blk  = swcfg_pkg::blk_start(i_fn_arg);
    assign wr_blk  = swcfg_pkg::blk_of(i_wr_addr);
    assign wr_stat = i_wr_valid && (i_wr_addr == swcfg_pkg::ADDR_STATUS);
    assign wr_ctrl = i_wr_valid && (i_wr_addr == swcfg_pkg::ADDR_NVCTRL);

    // Next-state logic for everything the block holds
    always_comb begin
        s_d           = s_q;
        s_d.init      = 1'b0;
        s_d.chg_start = 1'b0;
        s_d.chg_stop  = 1'b0;
        s_d.bus_rst   = link.reset_seen;
        s_d.rna_hit   = 1'b0;
        s_d.nv_we     = 1'b0;
        s_d.copy_go   = 1'b0;
        s_d.charge_supply_input       = i_charge_supply_input;
        s_d.addr      = {link.crc, link.id56};

        // Config straight from the nonvolatile byte, never shadow RAM
        if (s_q.init || (i_fn_valid && i_fn_code == swcfg_pkg::OP_REFRESH))
            s_d.cfg = i_nv_status_init & swcfg_pkg::ST_CFG_MASK;

        // Done is sticky; a write clears it, a new done still wins
        if (s_q.chg == swcfg_pkg::CHG_DONE && !wr_stat)
            s_d.chg = swcfg_pkg::CHG_DONE;
        else
            s_d.chg = i_charge_state;

        // Opcode answering the read net address command
        s_d.rna_op = s_d.cfg[swcfg_pkg::ST_RNA_SEL] ?
                     swcfg_pkg::OP_RNA1 : swcfg_pkg::OP_RNA0;
        // Only react to the master's commands; never initiate
        s_d.rna_hit = i_net_cmd_valid && (i_net_cmd == s_q.rna_op);

        // Charge start by command, or by supply arrival if selected
        if (i_fn_valid && i_fn_code == swcfg_pkg::OP_START)
            s_d.chg_start = 1'b1;
        if (s_q.cfg[swcfg_pkg::ST_CHARGE_INITIATION_SEL] && i_charge_supply_input && !s_q.charge_supply_input)
            s_d.chg_start = 1'b1;
        s_d.chg_stop = i_fn_valid && (i_fn_code == swcfg_pkg::OP_STOP);

        // Any function command drops lock-enable; a host write wins
        if (i_fn_valid)
            s_d.lock_en = 1'b0;
        if (wr_ctrl)
            s_d.lock_en = i_wr_data[swcfg_pkg::NV_LOCK_EN];

        // Lock only when enabled and named by a block start address
        if (i_fn_valid && i_fn_code == swcfg_pkg::OP_LOCK && s_q.lock_en
            && fn_blk != 2'h3 && !s_q.busy) begin
            s_d.blk_lock[fn_blk] = 1'b1;
            s_d.busy             = 1'b1;
            s_d.busy_cnt         = '0;
        end

        // Copy to an unlocked block holds busy for the whole copy
        if (i_fn_valid && i_fn_code == swcfg_pkg::OP_COPY && fn_blk != 2'h3
            && !s_q.blk_lock[fn_blk] && !s_q.busy) begin
            s_d.busy     = 1'b1;
            s_d.busy_cnt = '0;
            s_d.copy_go  = 1'b1;
            s_d.copy_blk = fn_blk;
        end else if (s_q.busy) begin
            if (s_q.busy_cnt == 32'(EEC_CYC - 1))
                s_d.busy = 1'b0;
            else
                s_d.busy_cnt = s_q.busy_cnt + 32'h1;
        end

        // Shadow writes pass unless busy or the block is locked
        if (i_wr_valid && wr_blk != 2'h3 && !s_q.busy
            && !s_q.blk_lock[wr_blk]) begin
            s_d.nv_we = 1'b1;
            s_d.nv_wa = i_wr_addr;
            s_d.nv_wd = i_wr_data;
        end

        // Sleep follows the line only while enabled
        if (s_q.cfg[swcfg_pkg::ST_SLEEP_EN]) begin
            if (i_dq)
                s_d.sleep = 1'b0;
            else if (link.long_low)
                s_d.sleep = 1'b1;
        end

        // Presence after a reset: wait for release, then pull low
        unique case (s_q.pr_st)
            swcfg_pkg::PR_IDLE: ;
            swcfg_pkg::PR_ARMED: begin
                if (i_dq) begin
                    s_d.pr_st  = swcfg_pkg::PR_WAIT;
                    s_d.pr_cnt = '0;
                end
            end
            swcfg_pkg::PR_WAIT: begin
                if (s_q.pr_cnt == 32'(swcfg_pkg::PRES_WAIT_CYC - 1)) begin
                    s_d.pr_st  = swcfg_pkg::PR_DRIVE;
                    s_d.pr_cnt = '0;
                end else
                    s_d.pr_cnt = s_q.pr_cnt + 32'h1;
            end
            swcfg_pkg::PR_DRIVE: begin
                if (s_q.pr_cnt == 32'(PRES_CYC - 1))
                    s_d.pr_st = swcfg_pkg::PR_IDLE;
                else
                    s_d.pr_cnt = s_q.pr_cnt + 32'h1;
            end
        endcase
        // A reset restarts the presence sequence from any state
        if (link.reset_seen)
            s_d.pr_st = swcfg_pkg::PR_ARMED;
        // Open drain: enable only to pull low
        s_d.oe_n = (s_d.pr_st != swcfg_pkg::PR_DRIVE);

        // Register reads; reserved bits and other addresses read zero
        if (i_rd_addr == swcfg_pkg::ADDR_STATUS)
            s_d.rd_data = {s_q.chg, s_q.cfg[5:0]};
        else if (i_rd_addr == swcfg_pkg::ADDR_NVCTRL)
            s_d.rd_data = {s_q.busy, s_q.lock_en, 3'h0,
                           s_q.blk_lock};
        else
            s_d.rd_data = swcfg_pkg::RESET_ZERO;
    end

    // Power-up schedules the config load on the first cycle after reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_q       <= '0;
            s_q.init  <= 1'b1;
            s_q.oe_n  <= 1'b1;
            s_q.rna_op <= swcfg_pkg::OP_RNA0;
        end else
            s_q <= s_d;
    end

    assign o_dq_out       = 1'b0;   // Constant low, never high
    assign o_dq_oe_n      = s_q.oe_n;
    assign o_bus_reset    = s_q.bus_rst;
    assign o_rna_hit      = s_q.rna_hit;
    assign o_rna_opcode   = s_q.rna_op;
    assign o_net_addr     = s_q.addr;
    assign o_rd_data      = s_q.rd_data;
    assign o_nv_wr_en     = s_q.nv_we;
    assign o_nv_wr_addr   = s_q.nv_wa;
    assign o_nv_wr_data   = s_q.nv_wd;
    assign o_nv_copy_go   = s_q.copy_go;
    assign o_nv_copy_blk  = s_q.copy_blk;
    assign o_nv_copy_busy = s_q.busy;
    assign o_blk_locked   = s_q.blk_lock;
    assign o_charge_start = s_q.chg_start;
    assign o_charge_stop  = s_q.chg_stop;
    assign o_chem_nimh    = s_q.cfg[swcfg_pkg::ST_CHARGE_CHEMISTRY_SEL];
    assign o_sleep        = s_q.sleep;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    done_hold_a: assert property (s_q.chg == swcfg_pkg::CHG_DONE && !wr_stat
        |=> o_rd_data[7:6] == swcfg_pkg::CHG_DONE || i_rd_addr != 8'h01
        ##0 s_q.chg == swcfg_pkg::CHG_DONE)
        else $error("done code dropped without a status write");
    refresh_load_a: assert property (i_fn_valid
        && i_fn_code == swcfg_pkg::OP_REFRESH
        |=> s_q.cfg == ($past(i_nv_status_init) & 8'h33))
        else $error("refresh did not reload config");
    sleep_hold_a: assert property (!s_q.cfg[5]
        |=> o_sleep == $past(o_sleep))
        else $error("sleep changed while disabled");
    sleep_wake_a: assert property (o_sleep && i_dq && s_q.cfg[5]
        |=> !o_sleep)
        else $error("sleep not left on high line");
    rna_opcode_a: assert property (##1 o_rna_opcode ==
        (s_q.cfg[4] ? 8'h39 : 8'h33))
        else $error("read address opcode mismatch");
    busy_write_a: assert property (o_nv_copy_busy && i_wr_valid
        && i_wr_addr >= 8'h20 && i_wr_addr <= 8'h47 |=> !o_nv_wr_en)
        else $error("nonvolatile write passed while busy");
    lock_ignore_a: assert property (i_fn_valid && i_fn_code == 8'h6A
        && !s_q.lock_en |=> $stable(o_blk_locked))
        else $error("lock applied while not enabled");
    lock_clear_a: assert property (i_fn_valid && !wr_ctrl
        |=> !s_q.lock_en ##1 1'b1)
        else $error("lock enable survived a command");
    lock_sticky_a: assert property ((o_blk_locked & ~$past(o_blk_locked))
        == 3'h0 || $past(i_fn_valid) || $past(i_rst))
        else $error("block lock changed without a command");
    copy_busy_a: assert property (o_nv_copy_go
        |-> o_nv_copy_busy [*2])
        else $error("copy busy not held");
    drain_only_a: assert property (o_dq_out == 1'b0)
        else $error("line driven high");
    reset_abort_a: assert property (o_bus_reset
        |-> $past(!i_dq, 2) ##1 s_q.pr_st == swcfg_pkg::PR_ARMED
        || i_dq)
        else $error("bus reset not taken");

    refresh_c: cover property (i_fn_valid && i_fn_code == 8'h63);
    lock_c:    cover property (o_blk_locked != 3'h0);
    sleep_c:   cover property (o_sleep);
    pres_c:    cover property (!o_dq_oe_n);
endmodule // swcfg_top

// *** hw/swcfg_pkg.sv ***
// Constants, types and decode helpers for the single-wire slave
// configuration controller. Assumes a 100 MHz system clock.
package swcfg_pkg;

    // Register map and field positions
    localparam logic [7:0] ADDR_STATUS   = 8'h01;
    localparam logic [7:0] ADDR_NVCTRL   = 8'h07;
    localparam logic [7:0] ADDR_NV_FIRST = 8'h20;
    localparam logic [7:0] ADDR_NV_LAST  = 8'h47;
    localparam logic [7:0] ADDR_BLK1     = 8'h30;
    localparam logic [7:0] ADDR_BLK2     = 8'h40;
    localparam logic [7:0] ADDR_STAT_NV  = 8'h31;
    localparam logic [7:0] ST_CFG_MASK   = 8'h33;
    localparam int         ST_SLEEP_EN   = 5;
    localparam int         ST_RNA_SEL    = 4;
    localparam int         ST_CHARGE_INITIATION_SEL       = 1;
    localparam int         ST_CHARGE_CHEMISTRY_SEL      = 0;
    localparam int         NV_LOCK_EN    = 6;
    localparam logic [7:0] RESET_ZERO    = 8'h00;

    // Charge state codes in the top two status bits
    localparam logic [1:0] CHG_NONE      = 2'h0;
    localparam logic [1:0] CHG_RUN       = 2'h1;
    localparam logic [1:0] CHG_SRC       = 2'h2;
    localparam logic [1:0] CHG_DONE      = 2'h3;

    // Opcodes
    localparam logic [7:0] OP_RNA0       = 8'h33;
    localparam logic [7:0] OP_RNA1       = 8'h39;
    localparam logic [7:0] OP_REFRESH    = 8'h63;
    localparam logic [7:0] OP_LOCK       = 8'h6A;
    localparam logic [7:0] OP_COPY       = 8'h48;
    localparam logic [7:0] OP_START      = 8'hB5;
    localparam logic [7:0] OP_STOP       = 8'hBE;

    // Address CRC, x^8+x^5+x^4+1 shifted lsb first
    localparam logic [7:0] CRC_POLY      = 8'h8C;
    // Arbitrary identity values, replaced per part
    localparam logic [7:0]  FAMILY_CODE  = 8'h5A;
    localparam logic [47:0] SERIAL_NUM   = 48'h0123456789AB;

    // Timing in native units, then in clock cycles
    localparam int CLK_MHZ        = 100;
    localparam int RESET_LOW_US   = 120;
    localparam int SLEEP_LOW_MS   = 2000;
    localparam int EEC_MS         = 10;
    localparam int PRES_WAIT_US   = 15;
    localparam int PRES_LEN_US    = 60;
    localparam int RESET_LOW_CYC  = RESET_LOW_US * CLK_MHZ + 1;
    localparam int SLEEP_LOW_CYC  = SLEEP_LOW_MS * 1000 * CLK_MHZ + 1;
    localparam int EEC_CYC        = EEC_MS * 1000 * CLK_MHZ;
    localparam int PRES_WAIT_CYC  = PRES_WAIT_US * CLK_MHZ;
    localparam int PRES_LEN_CYC   = PRES_LEN_US * CLK_MHZ;

    // Presence pulse sequencer
    typedef enum logic [1:0] {
        PR_IDLE  = 2'b00,
        PR_ARMED = 2'b01,
        PR_WAIT  = 2'b10,
        PR_DRIVE = 2'b11
    } swcfg_pres_e;

    // Block of a nonvolatile address: 0..2, or 3 when outside
    function automatic logic [1:0] blk_of(input logic [7:0] a);
        if (a < ADDR_NV_FIRST || a > ADDR_NV_LAST)
            return 2'h3;
        else if (a >= ADDR_BLK2)
            return 2'h2;
        else if (a >= ADDR_BLK1)
            return 2'h1;
        else
            return 2'h0;
    endfunction

    // Block named by its exact start address, else 3
    function automatic logic [1:0] blk_start(input logic [7:0] a);
        if (a[3:0] == 4'h0)
            return blk_of(a);
        else
            return 2'h3;
    endfunction

endpackage

// *** hw/swcfg_if.sv ***
// Carrier between the controller and its line monitor and CRC helper.
// Assumes all parties run on the one system clock.
`timescale 1ns/1ps
interface swcfg_if;
    logic        line_low;
    logic        reset_seen;
    logic        long_low;
    logic [55:0] id56;
    logic [7:0]  crc;

    modport ctl (output line_low, output id56,
                 input reset_seen, input long_low, input crc);
    modport mon (input line_low, output reset_seen, output long_low);
    modport gen (input id56, output crc);
endinterface // swcfg_if

// *** hw/swcfg_lowmon.sv ***
// Line-low duration monitor: flags a bus reset and a long low.
// Assumes the line level is already synchronous to i_clk.
`timescale 1ns/1ps
module swcfg_lowmon #(
    parameter int RESET_CYC = swcfg_pkg::RESET_LOW_CYC,
    parameter int SLEEP_CYC = swcfg_pkg::SLEEP_LOW_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    swcfg_if.mon      lk
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        rst_seen;
        logic        long_seen;
    } swcfg_mon_s;

    swcfg_mon_s s_q;
    swcfg_mon_s s_d;

    // Count low cycles; saturate so a stuck-low line stays long
    always_comb begin
        s_d          = s_q;
        s_d.rst_seen = 1'b0;
        if (!lk.line_low) begin
            s_d.cnt       = '0;
            s_d.long_seen = 1'b0;
        end else begin
            if (s_q.cnt != 32'hFFFFFFFF)
                s_d.cnt = s_q.cnt + 32'h1;
            s_d.rst_seen  = (s_q.cnt == 32'(RESET_CYC - 1));
            s_d.long_seen = (s_q.cnt >= 32'(SLEEP_CYC - 1));
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign lk.reset_seen = s_q.rst_seen;
    assign lk.long_low   = s_q.long_seen;
endmodule // swcfg_lowmon

// *** hw/swcfg_crc.sv ***
// Address CRC generator over family code and serial number.
// Assumes the identity bits are static after reset.
`timescale 1ns/1ps
module swcfg_crc (
    input  wire logic i_clk,
    input  wire logic i_rst,
    swcfg_if.gen      lk
);
    typedef struct packed {
        logic [7:0] crc;
    } swcfg_crc_s;

    swcfg_crc_s s_q;
    swcfg_crc_s s_d;

    // Start from zero, shift family then serial, lsb first
    // The value is only reported; nothing here compares it
    always_comb begin
        logic [7:0] c;
        logic       fb;
        c  = 8'h00;
        fb = 1'b0;
        for (int i = 0; i < 56; i++) begin
            fb = c[0] ^ lk.id56[i];
            c  = {1'b0, c[7:1]};
            if (fb)
                c = c ^ swcfg_pkg::CRC_POLY;
        end
        s_d.crc = c;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign lk.crc = s_q.crc;
endmodule // swcfg_crc

// *** verification/swcfg_host_model.sv ***
// Bus master stand-in for the single shared line.
// Assumes a pull-up at the master end and an open-drain device.
`timescale 1ns/1ps
module swcfg_host_model (
    input  wire logic i_clk,
    input  wire logic i_dev_oe_n,
    input  wire logic i_dev_out,
    output logic      o_line
);
    logic host_low = 1'b0;

    // Wired-AND with pull-up: a released line reads high
    // A device driving high would mask its own presence pulse
    assign o_line = !host_low && (i_dev_oe_n || i_dev_out);

    // Reset pulse by the only master, then back to idle high
    task automatic pulse(input int n);
        host_low = 1'b1;
        repeat (n) @(posedge i_clk);
        #1 host_low = 1'b0;
    endtask

    // Address check value: zero start, lsb first
    function automatic logic [7:0] crc8(input logic [55:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 56; i++)
            c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
        return c;
    endfunction
endmodule // swcfg_host_model

// *** verification/single_wire_slave_config_ctrl_test.sv ***
// Self-checking bench for the status/config and nonvolatile control.
// Assumes the bit engine is absent: commands are driven as pulses.
`timescale 1ns/1ps
module single_wire_slave_config_ctrl_test;
    logic        i_clk, i_rst, i_dq, i_net_cmd_valid, i_fn_valid;
    logic        i_wr_valid, i_charge_supply_input;
    logic [7:0]  i_net_cmd, i_fn_code, i_fn_arg, i_wr_addr, i_wr_data;
    logic [7:0]  i_rd_addr, i_nv_status_init, o_rd_data, o_rna_opcode;
    logic [1:0]  i_charge_state;
    logic [63:0] o_net_addr;
    logic [2:0]  o_blk_locked;
    logic        o_dq_oe_n, o_bus_reset, o_rna_hit, o_nv_wr_en, o_sleep;
    logic        o_nv_copy_go, o_nv_copy_busy, o_charge_start, o_chem_nimh;
    logic        o_charge_stop, o_dq_out;
    logic [7:0]  o_nv_wr_addr, o_nv_wr_data;
    logic [1:0]  o_nv_copy_blk;
    logic [6:0]  ev = 7'h00;
    logic        ev_clr = 1'b0;
    int          failures = 0;
    int          checked = 0;

    swcfg_host_model u_host (.i_clk, .i_dev_oe_n(o_dq_oe_n),
        .i_dev_out(o_dq_out), .o_line(i_dq));
    // Short counts keep the run brief; RESET_CYC stays above PRES_CYC
    swcfg_top #(.RESET_CYC(40), .SLEEP_CYC(200), .EEC_CYC(20),
        .PRES_CYC(10)) u_dut (.i_clk, .i_rst, .i_dq, .o_dq_out,
        .o_dq_oe_n, .o_bus_reset, .i_net_cmd_valid, .i_net_cmd, .o_rna_hit,
        .o_rna_opcode, .o_net_addr, .i_fn_valid, .i_fn_code, .i_fn_arg,
        .i_wr_valid, .i_wr_addr, .i_wr_data, .i_rd_addr, .o_rd_data,
        .o_nv_wr_en, .o_nv_wr_addr, .o_nv_wr_data, .o_nv_copy_go,
        .o_nv_copy_blk, .o_nv_copy_busy, .o_blk_locked, .i_nv_status_init,
        .i_charge_state, .i_charge_supply_input, .o_charge_start,
        .o_charge_stop, .o_chem_nimh, .o_sleep);

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Sticky record of pulses, so short ones are never missed
    // Presence counts only when the line really goes low
    always @(posedge i_clk) ev <= ev_clr ? 7'h00 : ev | {o_charge_stop,
        o_rna_hit, o_bus_reset, !o_dq_oe_n && !i_dq, o_charge_start,
        o_nv_copy_go, o_nv_wr_en};

    task automatic tick;
        @(posedge i_clk);
        #1;
    endtask

    // Clear the record across one edge; only the always block writes it
    task automatic clr_ev;
        ev_clr = 1'b1;
        tick;
        ev_clr = 1'b0;
    endtask

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_rd_addr = a;
        tick;
        tick;
        chk(o_rd_data, e);
    endtask

    // Write, function and net requests are one-cycle pulses
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        clr_ev;
        {i_wr_addr, i_wr_data, i_wr_valid} = {a, d, 1'b1};
        tick;
        i_wr_valid = 1'b0;
        repeat (2) tick;
    endtask

    task automatic fn(input logic [7:0] c, input logic [7:0] a);
        clr_ev;
        {i_fn_code, i_fn_arg, i_fn_valid} = {c, a, 1'b1};
        tick;
        i_fn_valid = 1'b0;
        repeat (2) tick;
    endtask

    task automatic t_init;
        rd(8'h01, 8'h73);
        rd(8'h07, 8'h00);
        rd(8'h05, 8'h00);
        chk(o_rna_opcode, 8'h39);
        chk(o_chem_nimh, 1'b1);
        chk(o_net_addr, {u_host.crc8({swcfg_pkg::SERIAL_NUM,
            swcfg_pkg::FAMILY_CODE}), swcfg_pkg::SERIAL_NUM,
            swcfg_pkg::FAMILY_CODE});
        clr_ev;
        {i_net_cmd, i_net_cmd_valid} = {8'h39, 1'b1};
        tick;
        i_net_cmd_valid = 1'b0;
        i_charge_supply_input = 1'b1;
        repeat (3) tick;
        chk(ev[5], 1'b1);
        chk(ev[2], 1'b1);
    endtask

    task automatic t_line(input logic sl);
        clr_ev;
        u_host.pulse(210);
        chk(o_sleep, sl);
        chk(ev[4], 1'b1);
        repeat (1600) tick;
        chk(ev[3], 1'b1);
        chk(o_sleep, 1'b0);
    endtask

    task automatic t_refresh;
        i_nv_status_init = 8'h00;
        fn(8'h63, 8'h00);
        rd(8'h01, 8'h40);
        chk(o_rna_opcode, 8'h33);
        chk(o_chem_nimh, 1'b0);
    endtask

    task automatic t_done;
        for (int s = 0; s < 4; s++) begin
            i_charge_state = 2'(s);
            rd(8'h01, {2'(s), 6'h00});
        end
        i_charge_state = 2'h0;
        rd(8'h01, 8'hC0);
        wr(8'h01, 8'h00);
        rd(8'h01, 8'h00);
    endtask

    task automatic t_lock;
        wr(8'h07, 8'hFF);
        rd(8'h07, 8'h40);
        fn(8'h6A, 8'h30);
        chk(o_blk_locked, 3'b010);
        rd(8'h07, 8'h82);
        repeat (25) tick;
        wr(8'h31, 8'h55);
        chk(ev[0], 1'b0);
        fn(8'h6A, 8'h20);
        chk(o_blk_locked, 3'b010);
        wr(8'h07, 8'h40);
        fn(8'hB5, 8'h00);
        chk(ev[2], 1'b1);
        fn(8'h6A, 8'h20);
        chk(o_blk_locked, 3'b010);
    endtask

    task automatic t_copy;
        fn(8'h48, 8'h40);
        chk(ev[1], 1'b1);
        chk(o_nv_copy_blk, 2'h2);
        wr(8'h42, 8'h5A);
        chk(ev[0], 1'b0);
        rd(8'h07, 8'h82);
        repeat (25) tick;
        rd(8'h07, 8'h02);
        wr(8'h42, 8'hA5);
        chk(ev[0], 1'b1);
        chk({o_nv_wr_addr, o_nv_wr_data}, 16'h42A5);
        fn(8'hBE, 8'h00);
        chk(ev[6], 1'b1);
    endtask

    task automatic final_report;
        if (failures == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        i_rst = 1'b1;
        {i_net_cmd_valid, i_fn_valid, i_wr_valid} = 3'h0;
        {i_net_cmd, i_fn_code, i_fn_arg, i_wr_addr} = 32'h0;
        {i_wr_data, i_rd_addr, i_nv_status_init} = {16'h0, 8'hFF};
        {i_charge_state, i_charge_supply_input} = {2'h1, 1'b0};
        repeat (8) tick;
        i_rst = 1'b0;
        repeat (2) tick;
        t_init;
        t_line(1'b1);
        t_refresh;
        t_line(1'b0);
        t_done;
        t_lock;
        t_copy;
        final_report;
    end

    // Whole run is near 38 us; this cuts a hang
    initial begin
        #200000;
        failures++;
        final_report;
    end
endmodule // single_wire_slave_config_ctrl_test
